/* File: core/l2sw_core.sv */
// layer-2 forwarding core: learn, look up, store, check, forward
`timescale 1ns/1ns
`default_nettype none
module l2sw_core #(
  parameter int unsigned NPORT = l2sw_pkg::NUM_PORTS,
  parameter int unsigned DEPTH = l2sw_pkg::TBL_DEPTH,
  parameter int unsigned FDEP  = l2sw_pkg::FRM_DEPTH
) (
  // clock and reset
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_rst_n,
  // ingress stream (one port at a time)
  input  wire logic                          i_rx_valid,
  input  wire logic [l2sw_pkg::DATA_W-1:0]   i_rx_data,
  input  wire logic                          i_rx_last,
  input  wire logic                          i_rx_err,
  input  wire logic [l2sw_pkg::PORT_W-1:0]   i_rx_port,
  output logic                               o_rx_ready,
  // egress stream with port mask
  output logic                               o_tx_valid,
  output logic [l2sw_pkg::DATA_W-1:0]        o_tx_data,
  output logic                               o_tx_last,
  output logic [NPORT-1:0]                   o_tx_mask,
  input  wire logic                          i_tx_ready,
  // link negotiation per port
  input  wire logic [NPORT-1:0]              i_link_up,
  input  wire logic [NPORT-1:0]              i_lp_aneg,
  input  wire logic [NPORT-1:0]              i_lp_100,
  output l2sw_pkg::l2sw_link_s [NPORT-1:0]   o_link,
  // frame statistics
  output logic                               o_drop_pulse,
  output logic                               o_err_pulse
);

  localparam int unsigned FA_W = $clog2(FDEP);
  localparam int unsigned TI_W = $clog2(DEPTH);
  localparam int unsigned W    = l2sw_pkg::DATA_W;
  localparam int unsigned HDR_W = l2sw_pkg::ADDR_BYTES * l2sw_pkg::DATA_W;

  l2sw_pkg::l2sw_state_e state_r;

  // frame store and address table
  logic [W-1:0]                 fbuf_r [FDEP];
  logic [FA_W-1:0]              wr_r;
  logic [FA_W-1:0]              rd_r;
  logic [FA_W-1:0]              len_r;
  logic                         ovf_r;
  logic                         bad_r;
  logic [l2sw_pkg::PORT_W-1:0]  in_port_r;
  logic [HDR_W-1:0]             hdr_r;
  logic [l2sw_pkg::MAC_W-1:0]   tmac_r [DEPTH];
  logic [l2sw_pkg::PORT_W-1:0]  tport_r [DEPTH];
  logic [DEPTH-1:0]             tval_r;
  logic [TI_W-1:0]              repl_r;
  logic [NPORT-1:0]             mask_r;

  // lookup over all entries
  logic [l2sw_pkg::MAC_W-1:0]   dmac;
  logic [l2sw_pkg::MAC_W-1:0]   smac;
  logic [DEPTH-1:0]             dhit;
  logic [DEPTH-1:0]             shit;
  logic [l2sw_pkg::PORT_W-1:0]  hit_port;
  logic [TI_W-1:0]              sidx;
  logic                         dfound;
  logic                         sfound;

  assign dmac = hdr_r[HDR_W-1 -: l2sw_pkg::MAC_W];
  assign smac = hdr_r[l2sw_pkg::MAC_W-1:0];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_cmp
      assign dhit[g] = tval_r[g] && (tmac_r[g] == dmac);
      assign shit[g] = tval_r[g] && (tmac_r[g] == smac);
    end
  endgenerate

  // priority select of matching entries
  always_comb begin
    hit_port = '0;
    sidx     = repl_r;
    dfound   = |dhit;
    sfound   = |shit;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (dhit[i]) begin
        hit_port = tport_r[i];
      end
      if (shit[i]) begin
        sidx = TI_W'(i);
      end
    end
  end

  // skid buffer carriers
  l2sw_pkg::l2sw_beat_s beat_in;
  l2sw_pkg::l2sw_beat_s beat_out;
  logic                 sk_valid;
  logic                 sk_ready;
  logic                 sk_ovalid;

  assign sk_valid     = (state_r == l2sw_pkg::L2SW_SEND);

  // ingress ready: shuts on a last byte, reopens once the frame has left or been dropped,
  // so the egress mask cannot change under a frame still stalled at the output
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_rx_ready <= 1'b1;
    end else if (i_rx_valid && o_rx_ready && i_rx_last) begin
      o_rx_ready <= 1'b0;
    end else if (state_r == l2sw_pkg::L2SW_DROP ||
                 (o_tx_valid && i_tx_ready && o_tx_last)) begin
      o_rx_ready <= 1'b1;
    end
  end
  assign beat_in.data = fbuf_r[rd_r];
  assign beat_in.last = (rd_r == len_r);

  // frame controller
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_r <= l2sw_pkg::L2SW_IDLE;
    end else begin
      case (state_r)
        l2sw_pkg::L2SW_IDLE: begin
          if (i_rx_valid && o_rx_ready) begin
            state_r <= i_rx_last ? l2sw_pkg::L2SW_LOOKUP : l2sw_pkg::L2SW_RECV;
          end
        end
        l2sw_pkg::L2SW_RECV: begin
          if (i_rx_valid && o_rx_ready && i_rx_last) begin
            state_r <= l2sw_pkg::L2SW_LOOKUP;
          end
        end
        l2sw_pkg::L2SW_LOOKUP: begin
          if (bad_r || ovf_r || (len_r < FA_W'(l2sw_pkg::ADDR_BYTES - 1))) begin
            state_r <= l2sw_pkg::L2SW_DROP;
          end else if (dfound && hit_port == in_port_r) begin
            state_r <= l2sw_pkg::L2SW_DROP;
          end else begin
            state_r <= l2sw_pkg::L2SW_SEND;
          end
        end
        l2sw_pkg::L2SW_SEND: begin
          if (sk_ready && rd_r == len_r) begin
            state_r <= l2sw_pkg::L2SW_IDLE;
          end
        end
        l2sw_pkg::L2SW_DROP: begin
          state_r <= l2sw_pkg::L2SW_IDLE;
        end
        default: begin
          state_r <= l2sw_pkg::L2SW_IDLE;
        end
      endcase
    end
  end

  // first byte of a frame lands at the bottom of the store
  logic [FA_W-1:0] waddr;
  assign waddr = (state_r == l2sw_pkg::L2SW_IDLE) ? '0 : wr_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_rx_valid && o_rx_ready && (!ovf_r || state_r == l2sw_pkg::L2SW_IDLE)) begin
      fbuf_r[waddr] <= i_rx_data;
    end
  end

  // receive bookkeeping and header capture
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      wr_r      <= '0;
      len_r     <= '0;
      ovf_r     <= 1'b0;
      bad_r     <= 1'b0;
      in_port_r <= '0;
      hdr_r     <= '0;
    end else if (i_rx_valid && o_rx_ready) begin
      if (state_r == l2sw_pkg::L2SW_IDLE) begin
        in_port_r <= i_rx_port;
        bad_r     <= i_rx_err;
        ovf_r     <= 1'b0;
        wr_r      <= FA_W'(1);
        len_r     <= '0;
      end else begin
        // remember any error in the frame
        bad_r <= bad_r | i_rx_err;
        ovf_r <= ovf_r | (wr_r == FA_W'(FDEP - 1));
        wr_r  <= wr_r + FA_W'(1);
        len_r <= wr_r;
      end
      // a wrapped pointer after overflow must not recapture the header
      if ((!ovf_r && wr_r < FA_W'(l2sw_pkg::ADDR_BYTES)) ||
          state_r == l2sw_pkg::L2SW_IDLE) begin
        hdr_r <= {hdr_r[HDR_W-W-1:0], i_rx_data};
      end
    end
  end

  // read pointer toward the skid buffer
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rd_r <= '0;
    end else if (state_r == l2sw_pkg::L2SW_LOOKUP) begin
      rd_r <= '0;
    end else if (sk_valid && sk_ready && rd_r != len_r) begin
      rd_r <= rd_r + FA_W'(1);
    end
  end

  // egress port mask from lookup
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      mask_r <= '0;
    end else if (state_r == l2sw_pkg::L2SW_LOOKUP) begin
      if (dfound) begin
        mask_r <= NPORT'(1) << hit_port;
      end else begin
        mask_r <= ~(NPORT'(1) << in_port_r);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      tval_r <= '0;
      repl_r <= '0;
    end else if (state_r == l2sw_pkg::L2SW_LOOKUP &&
                 len_r >= FA_W'(l2sw_pkg::ADDR_BYTES - 1)) begin
      tval_r[sidx] <= 1'b1;
      if (!sfound) begin
        repl_r <= repl_r + TI_W'(1);
      end
    end
  end

  // table entry storage
  // short frames carry no source and must not overwrite a live entry
  always_ff @(posedge i_ref_clk) begin
    if (state_r == l2sw_pkg::L2SW_LOOKUP && len_r >= FA_W'(l2sw_pkg::ADDR_BYTES - 1)) begin
      tmac_r[sidx]  <= smac;
      tport_r[sidx] <= in_port_r;
    end
  end

  // status pulses
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_drop_pulse <= 1'b0;
      o_err_pulse  <= 1'b0;
    end else begin
      o_drop_pulse <= (state_r == l2sw_pkg::L2SW_DROP);
      o_err_pulse  <= (state_r == l2sw_pkg::L2SW_LOOKUP) && (bad_r || ovf_r);
    end
  end

  l2sw_skid #(
    .W (W + 1)
  ) u_skid (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_valid   (sk_valid),
    .i_data    (beat_in),
    .o_ready   (sk_ready),
    .o_valid   (sk_ovalid),
    .o_data    (beat_out),
    .i_ready   (i_tx_ready || !o_tx_valid)
  );

  // registered egress stage
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_tx_valid <= 1'b0;
      o_tx_data  <= '0;
      o_tx_last  <= 1'b0;
      o_tx_mask  <= '0;
    end else if (i_tx_ready || !o_tx_valid) begin
      o_tx_valid <= sk_ovalid;
      o_tx_data  <= beat_out.data;
      o_tx_last  <= beat_out.last;
      o_tx_mask  <= mask_r;
    end
  end

  // link resolution per port
  logic [NPORT-1:0] up_d_r;
  generate
    for (g = 0; g < NPORT; g++) begin : g_link
      always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
          up_d_r[g] <= 1'b0;
          o_link[g] <= '0;
        end else begin
          up_d_r[g] <= i_link_up[g];
          if (i_link_up[g] && !up_d_r[g]) begin
            o_link[g].speed    <= i_lp_100[g] ? l2sw_pkg::SPD_100 : l2sw_pkg::SPD_10;
            o_link[g].full_dup <= i_lp_aneg[g];
          end
        end
      end
    end
  endgenerate

endmodule : l2sw_core
`default_nettype wire

/* File: core/l2sw_skid.sv */
// two-entry buffer between the frame sender and the egress stream
`timescale 1ns/1ns
`default_nettype none
module l2sw_skid #(
  parameter int unsigned W = 9
) (
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  // fill side
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  // drain side
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);

  logic [W-1:0] mem_r [2];
  logic         wptr_r;
  logic         rptr_r;
  logic [1:0]   cnt_r;
  logic         push;
  logic         pop;

  assign push    = i_valid && (cnt_r != 2'h2);
  assign pop     = (cnt_r != 2'h0) && i_ready;
  assign o_ready = (cnt_r != 2'h2);
  assign o_valid = (cnt_r != 2'h0);
  assign o_data  = mem_r[rptr_r];

  // storage write
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_r[wptr_r] <= i_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      wptr_r <= 1'b0;
      rptr_r <= 1'b0;
      cnt_r  <= 2'h0;
    end else begin
      if (push) begin
        wptr_r <= ~wptr_r;
      end
      if (pop) begin
        rptr_r <= ~rptr_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : l2sw_skid
`default_nettype wire

/* File: include/l2sw_pkg.sv */
// shared constants, enums and carriers of the layer-2 forwarding core
package l2sw_pkg;

  localparam int unsigned NUM_PORTS  = 8;
  localparam int unsigned PORT_W     = 3;
  localparam int unsigned MAC_W      = 48;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned TBL_DEPTH  = 16;
  localparam int unsigned FRM_DEPTH  = 2048;
  localparam int unsigned ADDR_BYTES = 12;      // destination then source
  localparam int unsigned DST_BYTES  = 6;

  // negotiation outcome encodings
  localparam logic [1:0] SPD_10  = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;

  typedef enum logic [4:0] {
    L2SW_IDLE   = 5'h01,
    L2SW_RECV   = 5'h02,
    L2SW_LOOKUP = 5'h04,
    L2SW_SEND   = 5'h08,
    L2SW_DROP   = 5'h10
  } l2sw_state_e;

  // one byte of frame stream with its end-of-frame mark
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              last;
  } l2sw_beat_s;

  // per-port result of link negotiation
  typedef struct packed {
    logic [1:0] speed;
    logic       full_dup;
  } l2sw_link_s;

endpackage : l2sw_pkg

/* File: tb/l2sw_core_asserts.sv */
// port-level assertion checker for the forwarding core
`timescale 1ns/1ns
`default_nettype none
module l2sw_core_asserts #(
  parameter int unsigned NPORT = 8
) (
  // clock, reset and ingress
  input wire logic                              i_ref_clk,
  input wire logic                              i_rst_n,
  input wire logic                              i_rx_valid,
  input wire logic                              i_rx_last,
  input wire logic [l2sw_pkg::PORT_W-1:0]       i_rx_port,
  input wire logic                              o_rx_ready,
  // egress, link and pulses
  input wire logic                              o_tx_valid,
  input wire logic [l2sw_pkg::DATA_W-1:0]       o_tx_data,
  input wire logic                              o_tx_last,
  input wire logic [NPORT-1:0]                  o_tx_mask,
  input wire logic                              i_tx_ready,
  input wire logic [NPORT-1:0]                  i_link_up,
  input wire logic [NPORT-1:0]                  i_lp_aneg,
  input wire logic [NPORT-1:0]                  i_lp_100,
  input wire l2sw_pkg::l2sw_link_s [NPORT-1:0]  o_link,
  input wire logic                              o_drop_pulse,
  input wire logic                              o_err_pulse
);
  logic                        acc_last;
  logic [l2sw_pkg::PORT_W-1:0] port_r;
  assign acc_last = i_rx_valid && o_rx_ready && i_rx_last;
  // ingress port of the frame just taken
  always_ff @(posedge i_ref_clk) begin
    if (acc_last) port_r <= i_rx_port;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  property p_tx_hold;
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_mask)
      && $stable(o_tx_last);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("beat moved in stall");
  property p_store;
    acc_last |=> !o_rx_ready [*2];
  endproperty
  a_store: assert property (p_store) else $error("ingress open after last");
  property p_not_back;
    o_tx_valid |-> !o_tx_mask[port_r];
  endproperty
  a_not_back: assert property (p_not_back) else $error("sent to ingress");
  property p_some_port;
    o_tx_valid |-> o_tx_mask != '0;
  endproperty
  a_some_port: assert property (p_some_port) else $error("empty mask");
  property p_err_quiet;
    o_err_pulse |-> !o_tx_valid ##1 !o_tx_valid;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("bad frame sent");
  property p_drop_one;
    o_drop_pulse |=> !o_drop_pulse;
  endproperty
  a_drop_one: assert property (p_drop_one) else $error("long drop pulse");
  property p_decide;
    acc_last |-> ##[2:8] (o_tx_valid || o_drop_pulse);
  endproperty
  a_decide: assert property (p_decide) else $error("no decision");
  property p_link;
    $rose(i_link_up[0]) |-> ##[1:3] 3'(o_link[0]) == {(i_lp_100[0] ? l2sw_pkg::SPD_100 :
      l2sw_pkg::SPD_10), i_lp_aneg[0]};
  endproperty
  a_link: assert property (p_link) else $error("link mode wrong");
endmodule : l2sw_core_asserts
`default_nettype wire

/* File: tb/l2sw_peer.sv */
// egress sink for the attached stations, stalling when slow
`timescale 1ns/1ns
`default_nettype none
module l2sw_peer (
  // clock and stall control
  input  wire logic       i_ref_clk,
  input  wire logic       i_slow,
  // egress stream
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  input  wire logic       i_last,
  input  wire logic [7:0] i_mask,
  output logic            o_ready
);
  logic [7:0] got_q[$];
  logic [7:0] mask_r = 8'h00;
  int         n_frm = 0;
  initial o_ready = 1'b1;
  // take beats; when slow, ready drops every other cycle
  always @(posedge i_ref_clk) begin
    if (i_valid && o_ready) begin
      got_q.push_back(i_data);
      mask_r <= i_mask;
      if (i_last) n_frm <= n_frm + 1;
    end
    o_ready <= !i_slow || !o_ready;
  end
endmodule : l2sw_peer
`default_nettype wire

/* File: tb/test_l2sw_core.sv */
// self-checking bench for the forwarding core
`timescale 1ns/1ns
`default_nettype none
module test_l2sw_core;
  logic        i_ref_clk = 1'b0, i_rst_n = 1'b0, slow = 1'b0;
  logic        i_rx_valid = 1'b0, i_rx_last = 1'b0, i_rx_err = 1'b0;
  logic [7:0]  i_rx_data = 8'h00, i_link_up = 8'h00, i_lp_aneg = 8'h00, i_lp_100 = 8'h00;
  logic [2:0]  i_rx_port = 3'h0;
  logic        o_rx_ready, o_tx_valid, o_tx_last, i_tx_ready, o_drop_pulse, o_err_pulse;
  logic [7:0]  o_tx_data, o_tx_mask;
  l2sw_pkg::l2sw_link_s [7:0] o_link;
  int          n_mismatch = 0, n_tests = 0, n_drop = 0, n_err = 0, cyc = 0;
  int          exp_frm = 0, exp_drop = 0;
  logic [31:0] rnd = 32'he9f0e058;
  int          tbl[logic [47:0]];
  logic [7:0]  sent[$];

  l2sw_core u_dut (.i_ref_clk, .i_rst_n, .i_rx_valid, .i_rx_data, .i_rx_last, .i_rx_err,
    .i_rx_port, .o_rx_ready, .o_tx_valid, .o_tx_data, .o_tx_last, .o_tx_mask, .i_tx_ready,
    .i_link_up, .i_lp_aneg, .i_lp_100, .o_link, .o_drop_pulse, .o_err_pulse);
  l2sw_peer u_peer (.i_ref_clk, .i_slow(slow), .i_valid(o_tx_valid), .i_data(o_tx_data),
    .i_last(o_tx_last), .i_mask(o_tx_mask), .o_ready(i_tx_ready));

  // clock
  always #5 i_ref_clk = ~i_ref_clk;
  // pulse counters and hang guard
  always @(posedge i_ref_clk) begin
    n_drop <= n_drop + int'(o_drop_pulse === 1'b1);
    n_err <= n_err + int'(o_err_pulse === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    n_tests++;
    if (exp !== got) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // send one frame and compare against the table model
  task automatic frame(input int d, input int s, input int p, input int len, input bit bad);
    logic [47:0] dm, sm;
    logic [7:0]  m;
    int          e0;
    dm = {40'h0200000000, 8'(d)};
    sm = {40'h0200000000, 8'(s)};
    e0 = n_err;
    m = 8'h00;
    sent.delete();
    u_peer.got_q.delete();
    for (int i = 0; i < len; i++) begin
      rnd = lfsr(rnd);
      sent.push_back(i < 6 ? dm[47-8*i -: 8] : i < 12 ? sm[95-8*i -: 8] : rnd[7:0]);
      i_rx_valid <= 1'b1;
      i_rx_data <= sent[i];
      i_rx_last <= (i == len - 1);
      i_rx_err <= bad && (i == len / 2);
      i_rx_port <= 3'(p);
      do @(posedge i_ref_clk); while (o_rx_ready !== 1'b1);
    end
    i_rx_valid <= 1'b0;
    i_rx_last <= 1'b0;
    i_rx_err <= 1'b0;
    if (len < 12 || bad) exp_drop++;
    else if (!tbl.exists(dm)) m = ~(8'h01 << p);
    else if (tbl[dm] == p) exp_drop++;
    else m = 8'h01 << tbl[dm];
    if (len >= 12) tbl[sm] = p;
    if (m != 8'h00) exp_frm++;
    for (int k = 0; k < 400; k++) begin
      @(posedge i_ref_clk);
      if (u_peer.n_frm == exp_frm && n_drop == exp_drop && o_rx_ready) break;
    end
    repeat (6) @(posedge i_ref_clk);
    chk("frames", exp_frm, u_peer.n_frm);
    chk("drops", exp_drop, n_drop);
    if (len >= 12) chk("err", bad, n_err - e0);
    if (m != 8'h00) begin
      chk("mask", m, u_peer.mask_r);
      chk("length", len, u_peer.got_q.size());
      foreach (sent[i]) chk("byte", sent[i], u_peer.got_q[i]);
    end
  endtask : frame

  task automatic end_of_test();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // main sequence
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    frame(1, 2, 1, 20, 0);
    frame(2, 3, 3, 16, 0);
    frame(3, 4, 3, 14, 0);
    frame(2, 5, 5, 30, 1);
    frame(5, 6, 0, 12, 0);
    frame(7, 8, 2, 8, 0);
    frame(8, 9, 4, 13, 0);
    slow <= 1'b1;
    for (int j = 0; j < 12; j++) begin
      rnd = lfsr(rnd);
      if (rnd[2:0] % 6 != rnd[6:4] % 6)
        frame(10 + rnd[2:0] % 6, 10 + rnd[6:4] % 6, (10 + rnd[6:4] % 6) % 8,
              12 + rnd[12:8], 0);
    end
    for (int j = 0; j < 6; j++) begin
      rnd = lfsr(rnd);
      i_lp_aneg <= rnd[7:0];
      i_lp_100 <= rnd[15:8];
      @(posedge i_ref_clk);
      i_link_up <= 8'hff;
      repeat (4) @(posedge i_ref_clk);
      for (int p = 0; p < 8; p++)
        chk("link", {(i_lp_100[p] ? l2sw_pkg::SPD_100 : l2sw_pkg::SPD_10), i_lp_aneg[p]},
            3'(o_link[p]));
      i_link_up <= 8'h00;
      repeat (4) @(posedge i_ref_clk);
    end
    end_of_test();
  end
endmodule : test_l2sw_core

bind l2sw_core l2sw_core_asserts #(.NPORT(NPORT)) u_chk (.i_ref_clk, .i_rst_n, .i_rx_valid,
  .i_rx_last, .i_rx_port, .o_rx_ready, .o_tx_valid, .o_tx_data, .o_tx_last, .o_tx_mask,
  .i_tx_ready, .i_link_up, .i_lp_aneg, .i_lp_100, .o_link, .o_drop_pulse, .o_err_pulse);
`default_nettype wire
